// file: inc/pgsbr_pkg.sv
// constants for the gigabit status, bypass control and error counter group
package pgsbr_pkg;
   // management register addresses
   localparam logic [4:0]  ADDR_GIG_STATUS_EXT_TWO = 5'h11;
   localparam logic [4:0]  ADDR_BYPASS_CONTROL     = 5'h12;
   localparam logic [4:0]  ADDR_RECEIVE_ERROR_CNT  = 5'h13;
   // gigabit status bit positions
   localparam int          ST_DESCR_LOCKED = 15;
   localparam int          ST_LOCK_ERR     = 14;
   localparam int          ST_DISCONNECT   = 13;
   localparam int          ST_LINK_ACTIVE  = 12;
   localparam int          ST_RX_ERR       = 11;
   localparam int          ST_TX_ERR       = 10;
   localparam int          ST_SSD_ERR      = 9;
   localparam int          ST_ESD_ERR      = 8;
   localparam int          ST_CEXT_ERR     = 7;
   localparam int          ST_LEGACY_DET   = 6;
   localparam int          ST_MDIX_ERR     = 5;
   // number of self-clearing status flags
   localparam int          SC_FLAGS = 7;
   // bypass control bit positions
   localparam int          BY_TX_DISABLE   = 15;
   localparam int          BY_TEST_CLOCK   = 8;
   localparam int          BY_FORCE_LEGACY = 7;
   localparam int          BY_LEGACY_OFF   = 6;
   localparam int          BY_NO_PAIR_SWAP = 5;
   localparam int          BY_NO_POLARITY  = 4;
   localparam int          BY_PD_HONOR     = 3;
   localparam int          BY_NO_AUTO_NP   = 1;
   localparam int          BY_CLOCK_OUT    = 0;
   // bypass writable bits, sticky bits and reset value (bit 0 from strap)
   localparam logic [15:0] BY_WR_MASK     = 16'h81fb;
   localparam logic [15:0] BY_STICKY_MASK = 16'h00fb;
   localparam logic [15:0] BY_RESET       = 16'h0048;
   // receive error counter width and ceiling
   localparam int          CNT_W   = 8;
   localparam logic [7:0]  CNT_MAX = 8'hff;
endpackage

// file: inc/pgsbr_ev_if.sv
// carrier between the register core, the flag bank and the error counter
`timescale 1ns/1ps
interface pgsbr_ev_if;
   logic [pgsbr_pkg::SC_FLAGS-1:0] sc_ev;    // flag set events
   logic                           sc_clr;   // clear-on-read strobe
   logic [pgsbr_pkg::SC_FLAGS-1:0] sc_flags; // latched flags
   logic                           cnt_inc;  // errored packet seen
   logic                           cnt_clr;  // counter clear strobe
   logic [pgsbr_pkg::CNT_W-1:0]    cnt_val;  // counter value
   modport core  (output sc_ev, sc_clr, cnt_inc, cnt_clr, input sc_flags, cnt_val);
   modport flags (input sc_ev, sc_clr, output sc_flags);
   modport count (input cnt_inc, cnt_clr, output cnt_val);
endinterface

// file: rtl/pgsbr_scflag.sv
// bank of self-clearing status flags, cleared by a read
`timescale 1ns/1ps
module pgsbr_scflag (
   input  wire logic clk,
   input  wire logic rst,
   pgsbr_ev_if.flags bus
);
   // one latch per flag; an event in the clearing cycle keeps it set
   for (genvar i = 0; i < pgsbr_pkg::SC_FLAGS; i++) begin : g_flag
      always_ff @(posedge clk) begin
         if (rst) begin
            bus.sc_flags[i] <= 1'b0;
         end else begin
            // set beats clear so no event is lost
            bus.sc_flags[i] <= bus.sc_ev[i] | (bus.sc_flags[i] & ~bus.sc_clr);
         end
      end
   end
endmodule

// file: rtl/pgsbr_errcnt.sv
// saturating receive error counter, cleared by read or reset
`timescale 1ns/1ps
module pgsbr_errcnt (
   input  wire logic clk,
   input  wire logic rst,
   pgsbr_ev_if.count bus
);
   logic cnt_full; // counter at its ceiling

   assign cnt_full = (bus.cnt_val == pgsbr_pkg::CNT_MAX);

   // count errored packets; a packet in the clearing cycle counts as one
   always_ff @(posedge clk) begin
      if (rst) begin
         bus.cnt_val <= '0;
      end else if (bus.cnt_clr) begin
         bus.cnt_val <= bus.cnt_inc ? 8'h01 : 8'h00;
      end else if (bus.cnt_inc && !cnt_full) begin
         bus.cnt_val <= bus.cnt_val + 8'h01;
      end
      // at the ceiling it simply holds, never wraps
   end
endmodule

// file: rtl/pgsbr_top.sv
// gigabit status, bypass control and receive error counter registers
`timescale 1ns/1ps
module pgsbr_top (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        SOFT_RST,
   input  wire logic [4:0]  MGMT_ADDR,
   input  wire logic        MGMT_WR,
   input  wire logic        MGMT_RD,
   input  wire logic [15:0] MGMT_WDATA,
   output      logic [15:0] MGMT_RDATA,
   input  wire logic        DESCR_LOCKED,
   input  wire logic        LOCK_ERR,
   input  wire logic        DISCONNECT,
   input  wire logic        LINK_ACTIVE,
   input  wire logic        RX_ERR,
   input  wire logic        TX_ERR,
   input  wire logic        SSD_ERR,
   input  wire logic        ESD_ERR,
   input  wire logic        CEXT_ERR,
   input  wire logic        LEGACY_DET,
   input  wire logic        MDIX_ERR,
   input  wire logic        PKT_ERR,
   input  wire logic        BASE_PAGE_DONE,
   input  wire logic        CONFIG_STRAP_DEFAULT,
   output      logic        TX_DISABLE,
   output      logic        TEST_CLOCK_EN,
   output      logic        LEGACY_MODE,
   output      logic        LEGACY_DETECT_EN,
   output      logic        PAIR_SWAP_CORR_EN,
   output      logic        POLARITY_CORR_EN,
   output      logic        PD_HONOR_ABILITY,
   output      logic        AUTO_NEXT_PAGE_EN,
   output      logic        NP_HANDOFF,
   output      logic        CLOCK_OUTPUT_PIN_EN
);
   pgsbr_ev_if  bus ();     // link to flag bank and counter

   logic [15:0] byp_q;      // bypass control register
   logic [15:0] byp_d;      // its next value
   logic        strap_s1_q; // strap synchroniser, first stage
   logic        strap_s2_q; // strap synchroniser, second stage
   logic        legacy_q;   // legacy partner status
   logic        np_q;       // next-page handoff to management
   logic [15:0] status_w;   // assembled gigabit status word
   logic [15:0] rd_mux;     // read data selected by address
   logic        rd_status;  // read of the status register
   logic        rd_count;   // read of the error counter
   logic        wr_bypass;  // write of the bypass register

   // decode management strobes
   assign rd_status = MGMT_RD && (MGMT_ADDR == pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO);
   assign rd_count  = MGMT_RD && (MGMT_ADDR == pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT);
   assign wr_bypass = MGMT_WR && (MGMT_ADDR == pgsbr_pkg::ADDR_BYPASS_CONTROL);

   // strap pin is asynchronous; two flops before anyone reads it
   always_ff @(posedge CLOCK) begin
      strap_s1_q <= CONFIG_STRAP_DEFAULT;
      strap_s2_q <= strap_s1_q;
   end

   // flag events, highest status bit first
   assign bus.sc_ev = {LOCK_ERR,
                       DISCONNECT,
                       RX_ERR,
                       TX_ERR,
                       SSD_ERR,
                       ESD_ERR,
                       CEXT_ERR};

   // flags clear on a status read or a soft reset
   assign bus.sc_clr = rd_status | SOFT_RST;

   // counter events: errored packets, cleared by read or soft reset
   assign bus.cnt_inc = PKT_ERR;
   assign bus.cnt_clr = rd_count | SOFT_RST;

   // self-clearing flag bank
   pgsbr_scflag u_flags (
      .clk (CLOCK),
      .rst (RST),
      .bus (bus)
   );

   // saturating receive error counter
   pgsbr_errcnt u_count (
      .clk (CLOCK),
      .rst (RST),
      .bus (bus)
   );

   // bypass next value: soft reset drops only non-sticky bits
   always_comb begin
      byp_d = byp_q;
      if (SOFT_RST) begin
         // a write in the same cycle loses to the soft reset
         byp_d = byp_q & pgsbr_pkg::BY_STICKY_MASK;
      end else if (wr_bypass) begin
         // reserved bits stay zero
         byp_d = MGMT_WDATA & pgsbr_pkg::BY_WR_MASK;
      end
   end

   // bypass register; bit 0 takes the synchronised strap at hard reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         byp_q <= pgsbr_pkg::BY_RESET | {15'h0000, strap_s2_q};
      end else begin
         byp_q <= byp_d;
      end
   end

   // legacy partner status, forced or gated by the bypass bits
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         legacy_q <= 1'b0;
      end else if (byp_q[pgsbr_pkg::BY_FORCE_LEGACY]) begin
         legacy_q <= 1'b1;
      end else begin
         // detection off means no detection at all
         legacy_q <= LEGACY_DET & ~byp_q[pgsbr_pkg::BY_LEGACY_OFF];
      end
   end

   // next-page handoff: held once the base page is done, until bit 1 drops
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         np_q <= 1'b0;
      end else if (!byp_q[pgsbr_pkg::BY_NO_AUTO_NP]) begin
         np_q <= 1'b0;
      end else if (BASE_PAGE_DONE) begin
         // from here management drives the page exchange
         np_q <= 1'b1;
      end
   end

   // control outputs straight from register flops
   assign TX_DISABLE          = byp_q[pgsbr_pkg::BY_TX_DISABLE];
   assign TEST_CLOCK_EN       = byp_q[pgsbr_pkg::BY_TEST_CLOCK];
   assign LEGACY_MODE         = legacy_q;
   assign LEGACY_DETECT_EN    = ~byp_q[pgsbr_pkg::BY_LEGACY_OFF];
   assign PAIR_SWAP_CORR_EN   = ~byp_q[pgsbr_pkg::BY_NO_PAIR_SWAP];
   assign POLARITY_CORR_EN    = ~byp_q[pgsbr_pkg::BY_NO_POLARITY];
   assign PD_HONOR_ABILITY    = byp_q[pgsbr_pkg::BY_PD_HONOR];
   assign AUTO_NEXT_PAGE_EN   = ~byp_q[pgsbr_pkg::BY_NO_AUTO_NP];
   assign NP_HANDOFF          = np_q;
   assign CLOCK_OUTPUT_PIN_EN = byp_q[pgsbr_pkg::BY_CLOCK_OUT];

   // status word; live bits are sampled into the read data flop
   always_comb begin
      status_w = 16'h0000; // reserved bits 4:0 read zero
      status_w[pgsbr_pkg::ST_DESCR_LOCKED] = DESCR_LOCKED;
      status_w[pgsbr_pkg::ST_LOCK_ERR]     = bus.sc_flags[6];
      status_w[pgsbr_pkg::ST_DISCONNECT]   = bus.sc_flags[5];
      status_w[pgsbr_pkg::ST_LINK_ACTIVE]  = LINK_ACTIVE;
      status_w[pgsbr_pkg::ST_RX_ERR]       = bus.sc_flags[4];
      status_w[pgsbr_pkg::ST_TX_ERR]       = bus.sc_flags[3];
      status_w[pgsbr_pkg::ST_SSD_ERR]      = bus.sc_flags[2];
      status_w[pgsbr_pkg::ST_ESD_ERR]      = bus.sc_flags[1];
      status_w[pgsbr_pkg::ST_CEXT_ERR]     = bus.sc_flags[0];
      status_w[pgsbr_pkg::ST_LEGACY_DET]   = legacy_q;
      status_w[pgsbr_pkg::ST_MDIX_ERR]     = MDIX_ERR;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      case (MGMT_ADDR)
         pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO: begin
            rd_mux = status_w;
         end
         pgsbr_pkg::ADDR_BYPASS_CONTROL: begin
            rd_mux = byp_q;
         end
         pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT: begin
            // upper byte reserved, reads zero
            rd_mux = {8'h00, bus.cnt_val};
         end
         default: begin
            rd_mux = 16'h0000;
         end
      endcase
   end

   // read data flop: loaded on a read, held otherwise
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         MGMT_RDATA <= 16'h0000;
      end else if (MGMT_RD) begin
         // value before any clear-on-read of the same edge
         MGMT_RDATA <= rd_mux;
      end
   end

   // checks on this block's behaviour
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   a_lock_live: assert property (
      rd_status |=> MGMT_RDATA[15] == $past(DESCR_LOCKED))
      else $error("descrambler lock bit wrong");

   a_lock_err_seen: assert property (
      (LOCK_ERR && !SOFT_RST) ##1 rd_status |=> MGMT_RDATA[14])
      else $error("lock error not reported");

   a_link_live: assert property (
      rd_status |=> MGMT_RDATA[12] == $past(LINK_ACTIVE) && MGMT_RDATA[4:0] == 5'h00)
      else $error("link bit or reserved bits wrong");

   a_flag_clear: assert property (
      rd_status && bus.sc_ev == '0 |=> bus.sc_flags == '0)
      else $error("flags not cleared after read");

   a_tx_disable: assert property (
      wr_bypass && !SOFT_RST |=> TX_DISABLE == $past(MGMT_WDATA[15]))
      else $error("transmit disable not written");

   a_legacy_force: assert property (
      byp_q[pgsbr_pkg::BY_FORCE_LEGACY] |=> LEGACY_MODE)
      else $error("legacy mode not forced");

   a_legacy_off: assert property (
      !byp_q[7] && byp_q[6] |=> !LEGACY_MODE)
      else $error("legacy detect not disabled");

   a_cnt_inc: assert property (
      PKT_ERR && !bus.cnt_clr && bus.cnt_val != 8'hff
      |=> bus.cnt_val == 8'($past(bus.cnt_val) + 8'h01))
      else $error("counter did not step");

   a_cnt_sat: assert property (
      bus.cnt_val == 8'hff && !bus.cnt_clr |=> bus.cnt_val == 8'hff)
      else $error("counter wrapped");

   a_cnt_clear: assert property (
      rd_count && !PKT_ERR |=> bus.cnt_val == 8'h00)
      else $error("counter not cleared by read");

   a_sticky_keep: assert property (
      SOFT_RST |=> (byp_q & 16'h00fb) == $past(byp_q & 16'h00fb) && !TX_DISABLE)
      else $error("soft reset disturbed bypass bits");

   a_np_handoff: assert property (
      byp_q[1] && BASE_PAGE_DONE && !wr_bypass |=> NP_HANDOFF && !AUTO_NEXT_PAGE_EN)
      else $error("next page handoff missing");

   a_disc_flag: assert property (
      DISCONNECT |=> bus.sc_flags[5])
      else $error("disconnect flag not set");

   a_rx_tx_flags: assert property (
      (RX_ERR |=> bus.sc_flags[4]) and (TX_ERR |=> bus.sc_flags[3]))
      else $error("receive or transmit error flag not set");

   a_delim_flags: assert property (
      (SSD_ERR |=> bus.sc_flags[2]) and (ESD_ERR |=> bus.sc_flags[1]))
      else $error("delimiter error flag not set");

   a_cext_flag: assert property (
      CEXT_ERR |=> bus.sc_flags[0])
      else $error("carrier extension flag not set");

   a_live_bits: assert property (
      rd_status |=> MGMT_RDATA[5] == $past(MDIX_ERR) && MGMT_RDATA[6] == $past(LEGACY_MODE))
      else $error("crossover or legacy bit wrong");

   a_corr_write: assert property (
      wr_bypass && !SOFT_RST |=> PAIR_SWAP_CORR_EN == !$past(MGMT_WDATA[5])
      && POLARITY_CORR_EN == !$past(MGMT_WDATA[4]))
      else $error("correction enables not written");

   a_pd_write: assert property (
      wr_bypass && !SOFT_RST |=> PD_HONOR_ABILITY == $past(MGMT_WDATA[3]))
      else $error("parallel detect control not written");

   a_clock_output_pin_write: assert property (
      wr_bypass && !SOFT_RST |=> CLOCK_OUTPUT_PIN_EN == $past(MGMT_WDATA[0]))
      else $error("clock output enable not written");

   // main scenarios
   c_cnt_saturate: cover property (bus.cnt_val == 8'hff ##1 rd_count);
   c_soft_reset:   cover property (byp_q[0] && SOFT_RST);
   c_np_handoff:   cover property (BASE_PAGE_DONE && byp_q[1] ##1 NP_HANDOFF);
   c_flag_read:    cover property (rd_status && bus.sc_flags != '0);
endmodule

// file: dv/pgsbr_mgmt_model.sv
// station management controller model driving the parallel register port
`timescale 1ns/1ps
module pgsbr_mgmt_model (
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   output      logic [4:0]  addr,
   output      logic        wr,
   output      logic        rd,
   output      logic [15:0] wdata
);
   // idle port at time zero
   initial begin
      addr = 5'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 16'h0000;
   end
   // one write strobe; data then goes to its inverse so stale values never match
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      wdata = ~d;
   endtask
   // one read strobe; data is registered, so it is taken after the next edge
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      d = rdata;
   endtask
   // pages resolved by software, so force the config and drop the handoff bit
   task automatic finish_pages(input logic [15:0] byp);
      wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, byp & 16'hfffd);
   endtask
endmodule

// file: dv/pgsbr_top_tb.sv
// self-checking bench for the status, bypass and error counter registers
`timescale 1ns/1ps
module pgsbr_top_tb;
   logic        clk, rst, soft_rst, descr, link, mdix, legacy, pkt, bpd, strap;
   logic [6:0]  ev;          // lock, disc, rx, tx, ssd, esd, cext events
   logic [4:0]  addr;
   logic        wr, rd;
   logic [15:0] wdata, rdata, got;
   logic [9:0]  ctl;         // all control outputs packed for one compare
   int          err_total, samples_checked, cyc;
   pgsbr_mgmt_model pgsbr_mgmt_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
      .rd(rd), .wdata(wdata));
   pgsbr_top pgsbr_top_i (.CLOCK(clk), .RST(rst), .SOFT_RST(soft_rst), .MGMT_ADDR(addr),
      .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
      .DESCR_LOCKED(descr), .LOCK_ERR(ev[6]), .DISCONNECT(ev[5]), .LINK_ACTIVE(link),
      .RX_ERR(ev[4]), .TX_ERR(ev[3]), .SSD_ERR(ev[2]), .ESD_ERR(ev[1]), .CEXT_ERR(ev[0]),
      .LEGACY_DET(legacy), .MDIX_ERR(mdix), .PKT_ERR(pkt), .BASE_PAGE_DONE(bpd),
      .CONFIG_STRAP_DEFAULT(strap), .TX_DISABLE(ctl[9]), .TEST_CLOCK_EN(ctl[8]),
      .LEGACY_MODE(ctl[7]), .LEGACY_DETECT_EN(ctl[6]), .PAIR_SWAP_CORR_EN(ctl[5]),
      .POLARITY_CORR_EN(ctl[4]), .PD_HONOR_ABILITY(ctl[3]), .AUTO_NEXT_PAGE_EN(ctl[2]),
      .NP_HANDOFF(ctl[1]), .CLOCK_OUTPUT_PIN_EN(ctl[0]));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // verdict in one place
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // hang guard, far above the roughly 730 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t %s got %h want %h", $time, what, g, e);
      end
   endtask
   // expected status word from the stimulus the bench itself applied
   function automatic logic [15:0] st_exp(input logic [6:0] f, input logic lg);
      return {descr, f[6:5], link, f[4:0], lg, mdix, 5'h00};
   endfunction
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string what);
      pgsbr_mgmt_model_i.rd_reg(a, got);
      chk(got, e, what);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // reset values of registers and controls, unmapped read
   task automatic t_reset();
      chk({6'h00, ctl}, 16'h003d, "reset ctl");
      rd_chk(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h0049, "reset bypass");
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0000, "reset status");
      rd_chk(pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT, 16'h0000, "reset count");
      rd_chk(5'h14, 16'h0000, "unmapped");
   endtask
   // each self-clearing flag alone, descrambler lock, link and crossover bits held up, legacy bit low, cleared after a read
   task automatic t_flags();
      descr = 1'b1;
      link = 1'b1;
      mdix = 1'b1;
      for (int i = 0; i < 7; i++) begin
         ev = 7'h01 << i;
         cycles(1);
         ev = 7'h00;
         rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, st_exp(7'h01 << i, 1'b0), "flag");
         rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, st_exp(7'h00, 1'b0), "clear");
      end
      descr = 1'b0;
      link = 1'b0;
      mdix = 1'b0;
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0000, "live low");
   endtask
   // legacy partner detection, its disable and its force
   task automatic t_legacy();
      legacy = 1'b1;
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0000, "det off");
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h0008);
      cycles(2);
      chk({6'h00, ctl}, 16'h00fc, "det on ctl");
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0040, "det on");
      legacy = 1'b0;
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h00c8);
      cycles(2);
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0040, "forced");
   endtask
   // all bits written, reserved bits read zero, soft reset keeps sticky bits
   task automatic t_bypass();
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'hffff);
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'hffff);
      rd_chk(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h81fb, "all ones");
      chk({6'h00, ctl}, 16'h0389, "ones ctl");
      rd_chk(pgsbr_pkg::ADDR_GIG_STATUS_EXT_TWO, 16'h0040, "status ro");
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h0000);
      // legacy mode flop lags the bypass write by one edge
      cycles(1);
      chk({6'h00, ctl}, 16'h0074, "zero ctl");
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'hffff);
      pkt = 1'b1;
      cycles(2);
      pkt = 1'b0;
      soft_rst = 1'b1;
      cycles(1);
      soft_rst = 1'b0;
      rd_chk(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h00fb, "soft sticky");
      rd_chk(pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT, 16'h0000, "soft count");
      // hard reset in mid-run with the strap low: sticky bits back to defaults
      strap = 1'b0;
      rst = 1'b1;
      cycles(4);
      rst = 1'b0;
      rd_chk(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h0048, "hard default");
   endtask
   // counting, clear on read and saturation
   task automatic t_count(input int n, input logic [15:0] e);
      for (int i = 0; i < n; i++) begin
         pkt = 1'b1;
         cycles(1);
         pkt = 1'b0;
         cycles(1);
      end
      rd_chk(pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT, e, "count");
      rd_chk(pgsbr_pkg::ADDR_RECEIVE_ERROR_CNT, 16'h0000, "count cleared");
   endtask
   // next pages handed to management, then returned by the controller
   task automatic t_next_page();
      pgsbr_mgmt_model_i.wr_reg(pgsbr_pkg::ADDR_BYPASS_CONTROL, 16'h004a);
      bpd = 1'b1;
      cycles(1);
      bpd = 1'b0;
      cycles(1);
      chk({15'h0000, ctl[1]}, 16'h0001, "handoff");
      chk({15'h0000, ctl[2]}, 16'h0000, "auto np off");
      pgsbr_mgmt_model_i.finish_pages(16'h004a);
      cycles(1);
      chk({15'h0000, ctl[1]}, 16'h0000, "handoff done");
   endtask
   // main sequence
   initial begin
      {soft_rst, descr, link, mdix, legacy, pkt, bpd, ev} = '0;
      strap = 1'b1;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_flags();
      t_legacy();
      t_bypass();
      t_count(3, 16'h0003);
      t_count(300, 16'h00ff);
      t_next_page();
      finish_test();
   end
endmodule
